// [core/tsi_pkg.sv]
// Constants for the temperature-sensor power-up initialisation block.
// Assumes a 20 MHz clock and a synchronous active-high reset.
package tsi_pkg;
    // Three-level strap codes from the analog front end.
    localparam logic [1:0] STRAP_LOW   = 2'h0;
    localparam logic [1:0] STRAP_FLOAT = 2'h1;
    localparam logic [1:0] STRAP_HIGH  = 2'h2;
    // Address prefix selected by the first strap.
    localparam logic [3:0] PFX_LOW     = 4'h3;
    localparam logic [3:0] PFX_FLOAT   = 4'h5;
    localparam logic [3:0] PFX_HIGH    = 4'h9;
    // Suffix base per first strap; second strap adds 0, 1 or 2.
    localparam logic [2:0] SFX_LOW     = 3'h0;
    localparam logic [2:0] SFX_FLOAT   = 3'h1;
    localparam logic [2:0] SFX_HIGH    = 3'h4;
    // Power-on values.
    localparam logic [7:0] CMD_PTR_RST    = 8'h00;
    localparam logic [7:0] CONV_RATE_RST  = 8'h06;
    localparam logic [7:0] UPPER_LIM_RST  = 8'h7f;
    localparam logic [7:0] LOWER_LIM_RST  = 8'hc9;
    localparam logic [7:0] HYST_RST       = 8'h0a;
    // Clock rate and the fastest conversion interval (channel one, 8 Hz).
    localparam int CLK_HZ       = 20_000_000;
    localparam int FAST_RATE_HZ = 8;
    localparam int FAST_CYCLES  = CLK_HZ / FAST_RATE_HZ;
    // Cycles allowed for the strap inputs to settle through the synchroniser.
    localparam int SETTLE_CYCLES = 4;
endpackage : tsi_pkg

// [core/tsi_rate_div.sv]
// Conversion tick generator: one-cycle pulses for both channel groups.
// Assumes rate_sel comes from logic on the same clock.
`timescale 1ns/100ps
module tsi_rate_div (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       run,
    input  wire logic [2:0] rate_sel,
    output logic            fast_tick,
    output logic            slow_tick
);
    logic [31:0] base_reg;
    logic [5:0]  oct_reg;
    logic        slow_ph_reg;
    logic        base_end;
    logic [5:0]  oct_lim;
    logic        oct_end;

    // Codes 6 and 7 share the fastest rate; each step lower halves it.
    // Code 0 needs 64 base periods, so the octave counter is six bits wide.
    assign oct_lim  = (rate_sel >= 3'h6) ? 6'h00 : (6'h01 << (3'h6 - rate_sel)) - 6'h01;
    assign base_end = (base_reg == 32'(tsi_pkg::FAST_CYCLES - 1));
    assign oct_end  = base_end && (oct_reg >= oct_lim);

    // The base counter always runs at 8 Hz; the octave counter divides it.
    always_ff @(posedge clk) begin
        if (reset || !run) begin
            base_reg    <= 32'h0000_0000;
            oct_reg     <= 6'h00;
            slow_ph_reg <= 1'b0;
            fast_tick   <= 1'b0;
            slow_tick   <= 1'b0;
        end else begin
            base_reg  <= base_end ? 32'h0000_0000 : base_reg + 32'h0000_0001;
            if (base_end) begin
                oct_reg <= oct_end ? 6'h00 : oct_reg + 6'h01;
            end
            if (oct_end) begin
                slow_ph_reg <= ~slow_ph_reg;
            end
            fast_tick <= oct_end;
            slow_tick <= oct_end && slow_ph_reg;
        end
    end
endmodule : tsi_rate_div

// [core/tsi_powerup_init.sv]
// Power-up initialisation: strap address latch, default register values,
// autonomous conversion start.
// Assumes the analog front end gives a two-bit three-level code per strap
// pin, asynchronous to clk; reset merges power-on and the external reset pin.
`timescale 1ns/100ps
module tsi_powerup_init (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [1:0] addr_strap_first,
    input  wire logic [1:0] addr_strap_second,
    input  wire logic       alert_event,
    input  wire logic       alert_clear,
    input  wire logic       rate_wr,
    input  wire logic [7:0] rate_wdata,
    input  wire logic       ptr_wr,
    input  wire logic [7:0] ptr_wdata,
    output logic [6:0]      slave_addr,
    output logic            addr_valid,
    output logic            alert_latched,
    output logic [7:0]      cmd_ptr,
    output logic [7:0]      conv_rate,
    output logic [7:0]      upper_temp_limit,
    output logic [7:0]      lower_temp_limit,
    output logic [7:0]      hysteresis,
    output logic            conv_fast_tick,
    output logic            conv_slow_tick
);
    typedef enum logic [2:0] {
        ST_SETTLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_RUN    = 3'b100
    } tsi_state_e;

    tsi_state_e  state_reg;
    tsi_state_e  state_next;
    logic [1:0]  s1_meta_reg;
    logic [1:0]  s1_sync_reg;
    logic [1:0]  s2_meta_reg;
    logic [1:0]  s2_sync_reg;
    logic [2:0]  settle_reg;
    logic [6:0]  decoded_addr;
    logic        run;
    logic        fast_tick;
    logic        slow_tick;

    // Decodes one strap pair into its address.
    function automatic logic [6:0] decode_addr(input logic [1:0] a, input logic [1:0] b);
        logic [3:0] pfx;
        logic [2:0] sfx;
        pfx = tsi_pkg::PFX_LOW;
        sfx = tsi_pkg::SFX_LOW;
        case (a)
            tsi_pkg::STRAP_FLOAT: begin
                pfx = tsi_pkg::PFX_FLOAT;
                sfx = tsi_pkg::SFX_FLOAT;
            end
            tsi_pkg::STRAP_HIGH: begin
                pfx = tsi_pkg::PFX_HIGH;
                sfx = tsi_pkg::SFX_HIGH;
            end
            default: begin
                pfx = tsi_pkg::PFX_LOW;
                sfx = tsi_pkg::SFX_LOW;
            end
        endcase
        // An illegal code on the second strap is treated as low.
        if (b == tsi_pkg::STRAP_FLOAT) begin
            sfx = sfx + 3'h1;
        end else if (b == tsi_pkg::STRAP_HIGH) begin
            sfx = sfx + 3'h2;
        end
        return {pfx, sfx};
    endfunction : decode_addr

    ////////////////////////////////////////////////////////////////////////
    // Strap synchronisers; the straps are analog levels off our clock.
    always_ff @(posedge clk) begin
        s1_meta_reg <= addr_strap_first;
        s1_sync_reg <= s1_meta_reg;
        s2_meta_reg <= addr_strap_second;
        s2_sync_reg <= s2_meta_reg;
    end

    assign decoded_addr = decode_addr(s1_sync_reg, s2_sync_reg);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: settle, sample once, then run until the next reset.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_SETTLE: begin
                if (settle_reg == 3'(tsi_pkg::SETTLE_CYCLES - 1)) begin
                    state_next = ST_SAMPLE;
                end
            end
            ST_SAMPLE: state_next = ST_RUN;
            ST_RUN:    state_next = ST_RUN;
            default:   state_next = ST_SETTLE;
        endcase
    end

    assign run = (state_reg == ST_RUN);

    // Sequencer state and settle counter; reset restarts sampling.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg  <= ST_SETTLE;
            settle_reg <= 3'h0;
        end else begin
            state_reg  <= state_next;
            settle_reg <= settle_reg + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address latch: written only in the sample state, so later strap
    // moves cost nothing and cannot disturb a live bus address.
    always_ff @(posedge clk) begin
        if (reset) begin
            slave_addr <= 7'h00;
            addr_valid <= 1'b0;
        end else if (state_reg == ST_SAMPLE) begin
            slave_addr <= decoded_addr;
            addr_valid <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-on register values; the set of the alert latch wins over a clear.
    always_ff @(posedge clk) begin
        if (reset) begin
            alert_latched    <= 1'b0;
            cmd_ptr          <= tsi_pkg::CMD_PTR_RST;
            conv_rate        <= tsi_pkg::CONV_RATE_RST;
            upper_temp_limit <= tsi_pkg::UPPER_LIM_RST;
            lower_temp_limit <= tsi_pkg::LOWER_LIM_RST;
            hysteresis       <= tsi_pkg::HYST_RST;
        end else begin
            if (alert_event) begin
                alert_latched <= 1'b1;
            end else if (alert_clear) begin
                alert_latched <= 1'b0;
            end
            if (rate_wr) begin
                conv_rate <= rate_wdata;
            end
            if (ptr_wr) begin
                cmd_ptr <= ptr_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion timing; only the low three rate bits matter.
    tsi_rate_div u_rate_div (
        .clk       (clk),
        .reset     (reset),
        .run       (run),
        .rate_sel  (conv_rate[2:0]),
        .fast_tick (fast_tick),
        .slow_tick (slow_tick)
    );

    // Tick outputs re-registered so every output is a flip-flop.
    always_ff @(posedge clk) begin
        if (reset) begin
            conv_fast_tick <= 1'b0;
            conv_slow_tick <= 1'b0;
        end else begin
            conv_fast_tick <= fast_tick;
            conv_slow_tick <= slow_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    AST_ADDR_DECODE: assert property (@(posedge clk) disable iff (reset)
        state_reg == ST_SAMPLE |=> slave_addr == $past(decoded_addr))
        else $error("latched address differs from decoded straps");
    AST_ALERT_CLEAR: assert property (@(posedge clk)
        reset |=> !alert_latched)
        else $error("alert latch not cleared by reset");
    AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (reset)
        addr_valid |=> $stable(slave_addr) && addr_valid)
        else $error("latched address moved after sampling");
    AST_ADDR_TIME: assert property (@(posedge clk)
        reset ##1 !reset [*6] |-> addr_valid)
        else $error("address not latched in time");
    AST_DEFAULTS: assert property (@(posedge clk)
        reset |=> cmd_ptr == 8'h00 && conv_rate == 8'h06 && hysteresis == 8'h0a)
        else $error("power-on defaults wrong");
    AST_LIMITS: assert property (@(posedge clk)
        reset |=> upper_temp_limit == 8'h7f && lower_temp_limit == 8'hc9)
        else $error("limit defaults wrong");
    AST_NO_EARLY: assert property (@(posedge clk) disable iff (reset)
        !addr_valid |-> !fast_tick)
        else $error("conversion before address latched");
    AST_HYST: assert property (@(posedge clk) disable iff (reset)
        $rose(addr_valid) |-> hysteresis == 8'h0a)
        else $error("hysteresis not ten at start");
    AST_SET_WINS: assert property (@(posedge clk) disable iff (reset)
        alert_event |=> alert_latched)
        else $error("alert event lost");

    COV_LATCH: cover property (@(posedge clk) $rose(addr_valid));
    COV_TICK:  cover property (@(posedge clk) conv_fast_tick);
    COV_RESAMPLE: cover property (@(posedge clk) addr_valid ##1 reset);
endmodule : tsi_powerup_init

// [bench/tsi_host_model.sv]
// Host-side model: issues command-pointer writes on the plain strobe.
// Assumes clk is the device clock and addr_valid comes from the device.
`timescale 1ns/100ps
module tsi_host_model (
    input  wire logic       clk,
    input  wire logic       addr_valid,
    input  wire logic       req,
    input  wire logic [7:0] req_data,
    output logic            ptr_wr,
    output logic [7:0]      ptr_wdata
);
    // Idle data toggles so a stale byte can never pass for a fresh one.
    initial begin
        ptr_wr    = 1'b0;
        ptr_wdata = 8'h00;
    end
    // A host holds off until the device owns an address.
    always @(negedge clk) begin
        ptr_wr    <= req & addr_valid;
        ptr_wdata <= req ? req_data : ~ptr_wdata;
    end
endmodule : tsi_host_model

// [bench/smbus_addr_strap_powerup_init_tb.sv]
// Bench for the power-up block: defaults, strap decode, latching, writes, alert.
// Assumes the design package is compiled first and one 20 MHz clock.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module smbus_addr_strap_powerup_init_tb;
    logic       clk, reset, alert_event, alert_clear, rate_wr, req, ptr_wr;
    logic       addr_valid, alert_latched, fast_tick, slow_tick;
    logic [1:0] strap_a, strap_b;
    logic [7:0] rate_wdata, req_data, ptr_wdata, cmd_ptr, conv_rate, upper, lower, hyst;
    logic [6:0] slave_addr;
    int         err_total, n_tests, i;
    logic [6:0] addr_tab [9] = '{7'h18, 7'h19, 7'h1a, 7'h29, 7'h2a, 7'h2b, 7'h4c, 7'h4d, 7'h4e};
    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 50 ns period.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    tsi_powerup_init dut (.clk(clk), .reset(reset), .addr_strap_first(strap_a),
        .addr_strap_second(strap_b), .alert_event(alert_event), .alert_clear(alert_clear),
        .rate_wr(rate_wr), .rate_wdata(rate_wdata), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata),
        .slave_addr(slave_addr), .addr_valid(addr_valid), .alert_latched(alert_latched),
        .cmd_ptr(cmd_ptr), .conv_rate(conv_rate), .upper_temp_limit(upper),
        .lower_temp_limit(lower), .hysteresis(hyst), .conv_fast_tick(fast_tick),
        .conv_slow_tick(slow_tick));
    tsi_host_model host (.clk(clk), .addr_valid(addr_valid), .req(req), .req_data(req_data),
        .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata));
    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then stops the run.
    task automatic summarize;
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    // Holds reset six cycles with new straps, checks defaults, then waits for the latch.
    task automatic do_reset(input logic [1:0] f, input logic [1:0] s);
        int n;
        @(negedge clk);
        reset <= 1'b1;
        strap_a <= f;
        strap_b <= s;
        repeat (6) @(negedge clk);
        `CHK("alert", 1'b0, alert_latched)
        `CHK("cmd_ptr", 8'h00, cmd_ptr)
        `CHK("upper", 8'h7f, upper)
        `CHK("lower", 8'hc9, lower)
        `CHK("hyst", 8'h0a, hyst)
        `CHK("conv_rate", 8'h06, conv_rate)
        `CHK("ticks", 2'h0, {fast_tick, slow_tick})
        `CHK("slave_addr rst", 7'h00, slave_addr)
        reset <= 1'b0;
        n = 0;
        @(negedge clk);
        `CHK("addr_valid early", 1'b0, addr_valid)
        while (addr_valid !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        `CHK("addr_valid", 1'b1, addr_valid)
    endtask : do_reset
    // One alert strobe pair, then the latch state one edge later.
    task automatic alert_step(input logic e, input logic c, input logic exp);
        @(negedge clk);
        alert_event <= e;
        alert_clear <= c;
        @(negedge clk);
        alert_event <= 1'b0;
        alert_clear <= 1'b0;
        `CHK("alert_latched", exp, alert_latched)
    endtask : alert_step
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; inputs change on the falling edge only.
    initial begin
        {reset, alert_event, alert_clear, rate_wr, req} = 5'h1f;
        {alert_event, alert_clear, rate_wr, req} = 4'h0;
        {strap_a, strap_b, rate_wdata, req_data} = 20'h0_0000;
        err_total = 0;
        n_tests = 0;
        for (i = 0; i < 9; i++) begin
            do_reset(2'(i / 3), 2'(i % 3));
            `CHK("slave_addr", addr_tab[i], slave_addr)
        end
        $display("test strap_decode done");
        strap_a <= 2'h0;
        strap_b <= 2'h1;
        repeat (10) @(negedge clk);
        `CHK("addr held", 7'h4e, slave_addr)
        $display("test strap_hold done");
        rate_wr <= 1'b1;
        rate_wdata <= 8'hf3;
        @(negedge clk);
        rate_wr <= 1'b0;
        rate_wdata <= 8'h0c;
        req <= 1'b1;
        req_data <= 8'h5a;
        @(negedge clk);
        `CHK("conv_rate", 8'hf3, conv_rate)
        req <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK("cmd_ptr", 8'h5a, cmd_ptr)
        `CHK("ticks idle", 2'h0, {fast_tick, slow_tick})
        alert_step(1'b1, 1'b0, 1'b1);
        alert_step(1'b0, 1'b1, 1'b0);
        alert_step(1'b1, 1'b1, 1'b1);
        $display("test writes_alert done");
        do_reset(2'h3, 2'h1);
        `CHK("slave_addr bad code", 7'h19, slave_addr)
        do_reset(2'h1, 2'h1);
        `CHK("slave_addr", 7'h2a, slave_addr)
        $display("test external_reset done");
        summarize();
    end
    // Watchdog well beyond the roughly 150 cycles the tests need.
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule : smbus_addr_strap_powerup_init_tb
